// ### brc_pkg.sv
package brc_pkg;

  // Timing base: the system clock and the one-microsecond tick.
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_TICK_NS = 1000;
  localparam int TICK_CYCLES = T_TICK_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 8;
  localparam logic [DIV_W-1:0] TICK_LAST = DIV_W'(TICK_CYCLES - 1);

  // Blanking and filter times, each in its own unit.
  localparam int T_BURST_BLANK_MS = 20;
  localparam int T_PROT_BLANK_MS = 20;
  localparam int T_SPIKE_US = 30;
  localparam int T_OVP_US = 120;
  localparam int T_EXT_BLANK_MS = 1;
  localparam int T_SOFT_START_MS = 20;

  // The same times as counts of microsecond ticks.
  localparam int TICKS_PER_US = 1000 / T_TICK_NS * 1000 / 1000;
  localparam int BURST_BLANK_TICKS = T_BURST_BLANK_MS * 1000 * 1000 / T_TICK_NS;
  localparam int PROT_BLANK_TICKS = T_PROT_BLANK_MS * 1000 * 1000 / T_TICK_NS;
  localparam int SPIKE_TICKS = T_SPIKE_US * 1000 / T_TICK_NS;
  localparam int OVP_TICKS = T_OVP_US * 1000 / T_TICK_NS;
  localparam int EXT_BLANK_TICKS = T_EXT_BLANK_MS * 1000 * 1000 / T_TICK_NS;
  localparam int SOFT_START_TICKS = T_SOFT_START_MS * 1000 * 1000 / T_TICK_NS;

  // Blanking timers.
  localparam int TMR_W = 16;
  localparam int TMR_BURST = 0;
  localparam int TMR_PROT = 1;
  localparam int TMR_SPIKE = 2;
  localparam int TMR_OVP = 3;
  localparam int TMR_EXT = 4;
  localparam int TMR_SOFT = 5;
  localparam int TMR_N = 6;

  // Positions of the comparator flags in the synchroniser vector.
  localparam int FL_FB_LOW = 0;
  localparam int FL_FB_WAKE = 1;
  localparam int FL_FB_SLEEP = 2;
  localparam int FL_FB_HIGH = 3;
  localparam int FL_VCC_SS_OVER = 4;
  localparam int FL_VCC_OVER = 5;
  localparam int FL_TEMP_OVER = 6;
  localparam int FL_BA_HIGH = 7;
  localparam int FL_BA_LOW = 8;
  localparam int FL_VCC_ON = 9;
  localparam int FL_VCC_OFF = 10;
  localparam int FL_N = 11;

  typedef enum logic [2:0] {
    ST_CHARGE,
    ST_SOFT_START,
    ST_NORMAL,
    ST_BURST_SLEEP,
    ST_BURST_RUN,
    ST_RESTART
  } ctl_state_t;

  typedef enum logic [2:0] {
    CAUSE_NONE,
    CAUSE_OVERLOAD,
    CAUSE_SS_OVP,
    CAUSE_OVP,
    CAUSE_TEMP,
    CAUSE_EXT,
    CAUSE_UV
  } cause_t;

endpackage : brc_pkg

// ### comp_sync.sv
`timescale 1ns/1ps
module comp_sync
  import brc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Raw comparator flags
  input wire logic [FL_N-1:0] raw_flags,
  // Flags in the clock domain
  output logic [FL_N-1:0] sync_flags
);

  typedef struct packed {
    logic [FL_N-1:0] meta;
    logic [FL_N-1:0] held;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  // Each flag passes two flip-flops; only the second is ever read.
  always_comb
  begin
    state_nxt.meta = raw_flags;
    state_nxt.held = state_r.meta;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign sync_flags = state_r.held;

endmodule : comp_sync

// ### blank_timer.sv
`timescale 1ns/1ps
module blank_timer
  import brc_pkg::*;
#(
  parameter int LIMIT = 1
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Timing
  input wire logic tick,
  input wire logic run,
  // Result
  output logic done
);

  localparam logic [TMR_W-1:0] LIMIT_W = TMR_W'(LIMIT);

  typedef struct packed {
    logic [TMR_W-1:0] count;
  } timer_state_t;

  timer_state_t state_r;
  timer_state_t state_nxt;

  // Counts ticks while run holds, saturates at the limit, clears at once.
  always_comb
  begin
    state_nxt = state_r;
    if (!run)
      state_nxt.count = '0;
    else if (tick && state_r.count != LIMIT_W)
      state_nxt.count = TMR_W'(state_r.count + 1'b1);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_r <= '0;
    else
      state_r <= state_nxt;
  end

  assign done = run && (state_r.count == LIMIT_W);

endmodule : blank_timer

// ### burst_and_restart_control.sv
// Functional notes
// - Feedback below 1.35V for 20ms enters burst.
// - Burst blanking counter held zero otherwise.
// - Burst entry sets flag, bias and switching off.
// - Start-up cell stays off throughout burst.
// - Feedback above 3.5V wakes bias and switching.
// - Burst selects reduced 0.34V current limit.
// - Feedback down to 3.0V sleeps bias again.
// - Feedback above 4.0V leaves burst, full current.
// - Burst entry uses fixed blanking only.
// - Feedback high 20ms releases blanking pin clamp.
// - Both high flags plus 30us enter restart.
// - Other faults enter auto-restart without extended blanking.
// - Restart: stop, charge supply, then start up.
// - After start-up recheck fault, restart or resume.
// - Soft-start supply above 20.5V with feedback high restarts.
// - Supply above 25.5V for 120us restarts, not burst.
// - Overtemperature enters auto-restart.
// - Blanking pin low stops switching, restarts; 1ms ignored.
// - Supply undervoltage switches off, start-up cell on.
// - Every restart attempt reruns soft-start.
`timescale 1ns/1ps
module burst_and_restart_control
  import brc_pkg::*;
#(
  parameter int BURST_BLANK = BURST_BLANK_TICKS,
  parameter int PROT_BLANK = PROT_BLANK_TICKS,
  parameter int EXT_BLANK = EXT_BLANK_TICKS,
  parameter int SOFT_START = SOFT_START_TICKS
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Feedback comparators
  input wire logic feedback_low_comparator,
  input wire logic burst_wake_comparator,
  input wire logic burst_sleep_comparator,
  input wire logic feedback_high_comparator,
  // Supply and temperature comparators
  input wire logic soft_start_supply_over,
  input wire logic supply_over_comparator,
  input wire logic temp_over,
  input wire logic supply_on,
  input wire logic supply_off,
  // Blanking pin comparators
  input wire logic blank_pin_high,
  input wire logic blank_pin_low,
  // Power stage controls
  output logic bias_en,
  output logic gate_en,
  output logic reduced_limit_gate,
  output logic startup_cell_en,
  output logic blank_clamp_switch_open,
  output logic soft_start_active,
  // Status
  output logic burst_flag,
  output logic restart_active,
  output cause_t restart_cause
);

  localparam int TMR_LIMIT [TMR_N] = '{
    BURST_BLANK,
    PROT_BLANK,
    SPIKE_TICKS,
    OVP_TICKS,
    EXT_BLANK,
    SOFT_START
  };

  typedef struct packed {
    ctl_state_t st;
    cause_t cause;
    logic [DIV_W-1:0] div;
    logic tick;
    logic bias_en;
    logic gate_en;
    logic reduced_limit;
    logic startup_cell_en;
    logic clamp_open;
    logic soft_start;
    logic burst;
    logic restart;
  } ctl_reg_t;

  localparam ctl_reg_t CTL_RESET = '{
    st: ST_CHARGE,
    cause: CAUSE_NONE,
    div: '0,
    tick: 1'b0,
    bias_en: 1'b0,
    gate_en: 1'b0,
    reduced_limit: 1'b0,
    startup_cell_en: 1'b1,
    clamp_open: 1'b0,
    soft_start: 1'b0,
    burst: 1'b0,
    restart: 1'b0
  };

  ctl_reg_t state_r;
  ctl_reg_t state_nxt;

  logic [FL_N-1:0] raw_flags;
  logic [FL_N-1:0] flags;
  logic [TMR_N-1:0] tmr_run;
  logic [TMR_N-1:0] tmr_done;

  logic fb_low;
  logic fb_wake;
  logic fb_sleep;
  logic fb_high;
  logic vcc_ss_over;
  logic vcc_over;
  logic hot;
  logic ba_high;
  logic ba_low;
  logic vcc_on;
  logic vcc_off;
  logic running;
  logic in_burst;
  logic ext_req;

  // States in which the converter is powered and may switch.
  function automatic logic is_running(input ctl_state_t s);
    is_running = (s == ST_SOFT_START) || (s == ST_NORMAL) ||
                 (s == ST_BURST_SLEEP) || (s == ST_BURST_RUN);
  endfunction : is_running

  function automatic logic is_burst(input ctl_state_t s);
    is_burst = (s == ST_BURST_SLEEP) || (s == ST_BURST_RUN);
  endfunction : is_burst

  // Whether the fault that caused the last restart is still present.
  function automatic logic cause_persists(input cause_t c,
                                          input logic [FL_N-1:0] f);
    case (c)
      CAUSE_OVERLOAD: cause_persists = f[FL_FB_HIGH];
      CAUSE_SS_OVP: cause_persists = f[FL_VCC_SS_OVER] && f[FL_FB_HIGH];
      CAUSE_OVP: cause_persists = f[FL_VCC_OVER];
      CAUSE_TEMP: cause_persists = f[FL_TEMP_OVER];
      CAUSE_EXT: cause_persists = f[FL_BA_LOW];
      default: cause_persists = 1'b0;
    endcase
  endfunction : cause_persists

  always_comb
  begin
    raw_flags = '0;
    raw_flags[FL_FB_LOW] = feedback_low_comparator;
    raw_flags[FL_FB_WAKE] = burst_wake_comparator;
    raw_flags[FL_FB_SLEEP] = burst_sleep_comparator;
    raw_flags[FL_FB_HIGH] = feedback_high_comparator;
    raw_flags[FL_VCC_SS_OVER] = soft_start_supply_over;
    raw_flags[FL_VCC_OVER] = supply_over_comparator;
    raw_flags[FL_TEMP_OVER] = temp_over;
    raw_flags[FL_BA_HIGH] = blank_pin_high;
    raw_flags[FL_BA_LOW] = blank_pin_low;
    raw_flags[FL_VCC_ON] = supply_on;
    raw_flags[FL_VCC_OFF] = supply_off;
  end

  comp_sync u_sync (
    .clk_sys (clk_sys),
    .rst (rst),
    .raw_flags (raw_flags),
    .sync_flags (flags)
  );

  assign fb_low = flags[FL_FB_LOW];
  assign fb_wake = flags[FL_FB_WAKE];
  assign fb_sleep = flags[FL_FB_SLEEP];
  assign fb_high = flags[FL_FB_HIGH];
  assign vcc_ss_over = flags[FL_VCC_SS_OVER];
  assign vcc_over = flags[FL_VCC_OVER];
  assign hot = flags[FL_TEMP_OVER];
  assign ba_high = flags[FL_BA_HIGH];
  assign ba_low = flags[FL_BA_LOW];
  assign vcc_on = flags[FL_VCC_ON];
  assign vcc_off = flags[FL_VCC_OFF];

  assign running = is_running(state_r.st);
  assign in_burst = is_burst(state_r.st);

  // The external request is blanked for the first part of each start-up.
  assign ext_req = tmr_done[TMR_EXT] && ba_low;

  always_comb
  begin
    tmr_run = '0;
    tmr_run[TMR_BURST] = (state_r.st == ST_NORMAL) && fb_low;
    tmr_run[TMR_PROT] = fb_high && ((state_r.st == ST_NORMAL) ||
                        (state_r.st == ST_SOFT_START));
    tmr_run[TMR_SPIKE] = (tmr_done[TMR_PROT] && ba_high) || ext_req;
    tmr_run[TMR_OVP] = running && !in_burst && vcc_over;
    tmr_run[TMR_EXT] = running;
    tmr_run[TMR_SOFT] = (state_r.st == ST_SOFT_START);
  end

  genvar t;
  generate
    for (t = 0; t < TMR_N; t++)
    begin : g_timer
      blank_timer #(
        .LIMIT (TMR_LIMIT[t])
      ) u_timer (
        .clk_sys (clk_sys),
        .rst (rst),
        .tick (state_r.tick),
        .run (tmr_run[t]),
        .done (tmr_done[t])
      );
    end
  endgenerate

  always_comb
  begin
    state_nxt = state_r;

    // One-cycle tick every microsecond.
    if (state_r.div == TICK_LAST)
      state_nxt.div = '0;
    else
      state_nxt.div = DIV_W'(state_r.div + 1'b1);
    state_nxt.tick = (state_r.div == TICK_LAST);

    case (state_r.st)
      ST_CHARGE:
      begin
        if (vcc_on)
          state_nxt.st = ST_SOFT_START;
      end
      ST_RESTART:
      begin
        if (vcc_off)
          state_nxt.st = ST_CHARGE;
      end
      ST_SOFT_START, ST_NORMAL, ST_BURST_SLEEP, ST_BURST_RUN:
      begin
        // Fast faults first; only the last, overload, waits for extended blanking.
        if (vcc_off)
        begin
          state_nxt.st = ST_CHARGE;
          state_nxt.cause = CAUSE_UV;
        end
        else if (hot)
        begin
          state_nxt.st = ST_RESTART;
          state_nxt.cause = CAUSE_TEMP;
        end
        else if (tmr_done[TMR_OVP])
        begin
          state_nxt.st = ST_RESTART;
          state_nxt.cause = CAUSE_OVP;
        end
        else if ((state_r.st == ST_SOFT_START) && vcc_ss_over && fb_high)
        begin
          state_nxt.st = ST_RESTART;
          state_nxt.cause = CAUSE_SS_OVP;
        end
        else if (tmr_done[TMR_SPIKE] && ext_req)
        begin
          state_nxt.st = ST_RESTART;
          state_nxt.cause = CAUSE_EXT;
        end
        else if (tmr_done[TMR_SPIKE] && fb_high)
        begin
          state_nxt.st = ST_RESTART;
          state_nxt.cause = CAUSE_OVERLOAD;
        end
        else
        begin
          case (state_r.st)
            ST_SOFT_START:
            begin
              if (tmr_done[TMR_SOFT])
              begin
                if (cause_persists(state_r.cause, flags))
                  state_nxt.st = ST_RESTART;
                else
                begin
                  state_nxt.st = ST_NORMAL;
                  state_nxt.cause = CAUSE_NONE;
                end
              end
            end
            ST_NORMAL:
            begin
              if (tmr_done[TMR_BURST] && fb_low)
                state_nxt.st = ST_BURST_SLEEP;
            end
            ST_BURST_SLEEP:
            begin
              if (fb_high)
                state_nxt.st = ST_NORMAL;
              else if (fb_wake)
                state_nxt.st = ST_BURST_RUN;
            end
            ST_BURST_RUN:
            begin
              if (fb_high)
                state_nxt.st = ST_NORMAL;
              else if (fb_sleep)
                state_nxt.st = ST_BURST_SLEEP;
            end
            default:
            begin
              state_nxt.st = ST_CHARGE;
            end
          endcase
        end
      end
      default:
      begin
        state_nxt.st = ST_CHARGE;
      end
    endcase

    // Outputs follow the state being entered, so they change with it.
    state_nxt.bias_en = (state_nxt.st == ST_SOFT_START) ||
                        (state_nxt.st == ST_NORMAL) ||
                        (state_nxt.st == ST_BURST_RUN);
    state_nxt.gate_en = state_nxt.bias_en && !ext_req;
    state_nxt.burst = is_burst(state_nxt.st);
    state_nxt.reduced_limit = is_burst(state_nxt.st);
    state_nxt.startup_cell_en = (state_nxt.st == ST_CHARGE);
    state_nxt.soft_start = (state_nxt.st == ST_SOFT_START);
    state_nxt.clamp_open = tmr_done[TMR_PROT] &&
                           is_running(state_nxt.st);
    state_nxt.restart = (state_nxt.st == ST_RESTART) ||
                        ((state_nxt.st == ST_CHARGE) &&
                         (state_nxt.cause != CAUSE_NONE));
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      state_r <= CTL_RESET;
    else
      state_r <= state_nxt;
  end

  assign bias_en = state_r.bias_en;
  assign gate_en = state_r.gate_en;
  assign reduced_limit_gate = state_r.reduced_limit;
  assign startup_cell_en = state_r.startup_cell_en;
  assign blank_clamp_switch_open = state_r.clamp_open;
  assign soft_start_active = state_r.soft_start;
  assign burst_flag = state_r.burst;
  assign restart_active = state_r.restart;
  assign restart_cause = state_r.cause;

endmodule : burst_and_restart_control

// ### brc_chk.sv
`timescale 1ns/1ps
module brc_chk
  import brc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Watched inputs
  input wire logic feedback_high_comparator,
  input wire logic burst_wake_comparator,
  input wire logic burst_sleep_comparator,
  input wire logic temp_over,
  input wire logic supply_on,
  input wire logic supply_off,
  // Watched outputs
  input wire logic bias_en,
  input wire logic gate_en,
  input wire logic reduced_limit_gate,
  input wire logic startup_cell_en,
  input wire logic soft_start_active,
  input wire logic burst_flag,
  input wire logic restart_active
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_burst_cell_off: assert property (burst_flag |-> !startup_cell_en)
    else $error("start-up cell on in burst");
  a_burst_entry_off: assert property ($rose(burst_flag) |->
    !bias_en && !gate_en)
    else $error("bias left on at burst entry");
  a_burst_limit: assert property (burst_flag |-> reduced_limit_gate)
    else $error("reduced limit not selected in burst");
  a_wake_bias: assert property ($rose(burst_wake_comparator) && burst_flag
    |-> ##[1:4] (bias_en || !burst_flag))
    else $error("bias not woken in burst");
  a_sleep_bias: assert property ($rose(burst_sleep_comparator) && burst_flag
    && !burst_wake_comparator |-> ##[1:4] (!bias_en || !burst_flag))
    else $error("bias not put to sleep in burst");
  a_burst_exit: assert property ($rose(feedback_high_comparator) && burst_flag
    |-> ##[1:4] (!burst_flag && !reduced_limit_gate))
    else $error("burst not left on high feedback");
  a_temp_stop: assert property ($rose(temp_over) |-> ##[1:4] !gate_en)
    else $error("switching not stopped on overtemperature");
  a_uv_cell_on: assert property ($rose(supply_off) |->
    ##[1:4] startup_cell_en)
    else $error("start-up cell not enabled on undervoltage");
  a_restart_quiet: assert property (restart_active |-> !gate_en && !bias_en)
    else $error("switching during auto-restart");
  a_start_soft: assert property ($rose(supply_on) && startup_cell_en
    && !supply_off |-> ##[1:4] (!startup_cell_en && soft_start_active))
    else $error("no soft-start after supply turn-on");
endmodule : brc_chk

bind burst_and_restart_control brc_chk i_brc_chk (
  .clk_sys(clk_sys), .rst(rst),
  .feedback_high_comparator(feedback_high_comparator),
  .burst_wake_comparator(burst_wake_comparator),
  .burst_sleep_comparator(burst_sleep_comparator),
  .temp_over(temp_over), .supply_on(supply_on), .supply_off(supply_off),
  .bias_en(bias_en), .gate_en(gate_en),
  .reduced_limit_gate(reduced_limit_gate),
  .startup_cell_en(startup_cell_en),
  .soft_start_active(soft_start_active),
  .burst_flag(burst_flag), .restart_active(restart_active)
);

// ### testbench.sv
`timescale 1ns/1ps
`define chk(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) \
    begin \
      num_errors++; \
      $display("mismatch %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module testbench;
  import brc_pkg::*;
  localparam int BB = 20;
  localparam int PB = 20;
  localparam int EB = 5;
  localparam int SS = 40;
  localparam int TC = TICK_CYCLES;
  logic clk_sys, rst;
  logic fb_low, wake, sleep, fb_high, ss_over, vcc_over, temp_over;
  logic supply_on, supply_off, pin_high, pin_low;
  logic bias_en, gate_en, reduced_limit_gate, startup_cell_en;
  logic blank_clamp_switch_open, soft_start_active, burst_flag, restart_active;
  cause_t restart_cause;
  int num_errors, checks_done, n;
  logic [31:0] seed;

  burst_and_restart_control #(.BURST_BLANK(BB), .PROT_BLANK(PB),
    .EXT_BLANK(EB), .SOFT_START(SS)) i_burst_and_restart_control (
    .clk_sys(clk_sys), .rst(rst), .feedback_low_comparator(fb_low),
    .burst_wake_comparator(wake), .burst_sleep_comparator(sleep),
    .feedback_high_comparator(fb_high), .soft_start_supply_over(ss_over),
    .supply_over_comparator(vcc_over), .temp_over(temp_over),
    .supply_on(supply_on), .supply_off(supply_off),
    .blank_pin_high(pin_high), .blank_pin_low(pin_low),
    .bias_en(bias_en), .gate_en(gate_en),
    .reduced_limit_gate(reduced_limit_gate),
    .startup_cell_en(startup_cell_en),
    .blank_clamp_switch_open(blank_clamp_switch_open),
    .soft_start_active(soft_start_active), .burst_flag(burst_flag),
    .restart_active(restart_active), .restart_cause(restart_cause));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic pick(input int s);
    case (s)
      0: return burst_flag;
      1: return blank_clamp_switch_open;
      2: return restart_active;
      default: return soft_start_active;
    endcase
  endfunction : pick

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test

  task automatic step(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : step

  // Counts cycles in n until the chosen output reaches v.
  task automatic wait_on(input int s, input logic v, input int lim);
    n = 0;
    while (pick(s) !== v)
    begin
      step(1);
      n++;
      if (n > lim)
      begin
        num_errors++;
        $display("mismatch wait %0d exp %0h got %0h", s, v, pick(s));
        end_of_test();
      end
    end
  endtask : wait_on

  task automatic recharge();
    @(posedge clk_sys);
    supply_on <= 1'b0;
    supply_off <= 1'b1;
    step(4);
    `chk("cell", 1'b1, startup_cell_en);
    @(posedge clk_sys);
    supply_off <= 1'b0;
    supply_on <= 1'b1;
    step(4);
    `chk("cell", 1'b0, startup_cell_en);
    `chk("soft", 1'b1, soft_start_active);
  endtask : recharge

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  initial
  begin
    {fb_low, wake, sleep, fb_high, ss_over, vcc_over} = '0;
    {temp_over, supply_on, supply_off, pin_high, pin_low} = '0;
    rst = 1'b1;
    num_errors = 0;
    checks_done = 0;
    seed = 32'h68fa5dcc;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    step(2);
    `chk("cell", 1'b1, startup_cell_en);
    `chk("gate", 1'b0, gate_en);
    @(posedge clk_sys);
    supply_on <= 1'b1;
    step(4);
    `chk("gate", 1'b1, gate_en);
    wait_on(3, 1'b0, (SS + 2) * TC);
    `chk("restart", 1'b0, restart_active);
    $display("test power-up done");
    repeat (2)
    begin
      seed = lfsr(seed);
      @(posedge clk_sys);
      fb_low <= 1'b1;
      step(20 + int'(seed % 3000));
      @(posedge clk_sys);
      fb_low <= 1'b0;
      step(4);
      `chk("burst", 1'b0, burst_flag);
    end
    @(posedge clk_sys);
    fb_low <= 1'b1;
    wait_on(0, 1'b1, (BB + 2) * TC);
    `chk("burst time", 1'b1, n >= (BB - 1) * TC);
    `chk("bias", 1'b0, bias_en);
    `chk("gate", 1'b0, gate_en);
    `chk("limit", 1'b1, reduced_limit_gate);
    `chk("cell", 1'b0, startup_cell_en);
    @(posedge clk_sys);
    fb_low <= 1'b0;
    wake <= 1'b1;
    step(4);
    `chk("bias", 1'b1, bias_en);
    `chk("gate", 1'b1, gate_en);
    @(posedge clk_sys);
    wake <= 1'b0;
    sleep <= 1'b1;
    step(4);
    `chk("bias", 1'b0, bias_en);
    @(posedge clk_sys);
    sleep <= 1'b0;
    vcc_over <= 1'b1;
    step(OVP_TICKS * TC + 1000);
    `chk("restart", 1'b0, restart_active);
    `chk("burst", 1'b1, burst_flag);
    $display("test burst done");
    @(posedge clk_sys);
    vcc_over <= 1'b0;
    fb_high <= 1'b1;
    step(4);
    `chk("burst", 1'b0, burst_flag);
    `chk("limit", 1'b0, reduced_limit_gate);
    wait_on(1, 1'b1, (PB + 2) * TC);
    `chk("clamp time", 1'b1, n + 4 >= (PB - 1) * TC);
    `chk("restart", 1'b0, restart_active);
    @(posedge clk_sys);
    pin_high <= 1'b1;
    wait_on(2, 1'b1, (SPIKE_TICKS + 2) * TC);
    `chk("spike time", 1'b1, n >= (SPIKE_TICKS - 1) * TC);
    `chk("cause", CAUSE_OVERLOAD, restart_cause);
    recharge();
    wait_on(2, 1'b1, (PB + SPIKE_TICKS + 4) * TC);
    `chk("cause", CAUSE_OVERLOAD, restart_cause);
    $display("test overload done");
    @(posedge clk_sys);
    fb_high <= 1'b0;
    pin_high <= 1'b0;
    recharge();
    @(posedge clk_sys);
    ss_over <= 1'b1;
    fb_high <= 1'b1;
    step(4);
    `chk("restart", 1'b1, restart_active);
    `chk("cause", CAUSE_SS_OVP, restart_cause);
    @(posedge clk_sys);
    ss_over <= 1'b0;
    fb_high <= 1'b0;
    recharge();
    wait_on(3, 1'b0, (SS + 2) * TC);
    `chk("restart", 1'b0, restart_active);
    `chk("gate", 1'b1, gate_en);
    @(posedge clk_sys);
    temp_over <= 1'b1;
    step(4);
    `chk("gate", 1'b0, gate_en);
    `chk("cause", CAUSE_TEMP, restart_cause);
    @(posedge clk_sys);
    temp_over <= 1'b0;
    recharge();
    @(posedge clk_sys);
    pin_low <= 1'b1;
    step(4);
    `chk("gate", 1'b1, gate_en);
    step((EB + 2) * TC);
    `chk("gate", 1'b0, gate_en);
    `chk("restart", 1'b0, restart_active);
    wait_on(2, 1'b1, (SPIKE_TICKS + 4) * TC);
    `chk("cause", CAUSE_EXT, restart_cause);
    @(posedge clk_sys);
    pin_low <= 1'b0;
    recharge();
    @(posedge clk_sys);
    supply_on <= 1'b0;
    supply_off <= 1'b1;
    step(4);
    `chk("cell", 1'b1, startup_cell_en);
    `chk("cause", CAUSE_UV, restart_cause);
    $display("test faults done");
    end_of_test();
  end
endmodule : testbench
